// ===== logic/adsq_cfg.svh
// Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes inclusion by the sequencer package and top module only.
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH

// Register offsets on the plain register port
`define ADSQ_OFS_CTRL1     4'h0
`define ADSQ_OFS_CTRL2     4'h1
`define ADSQ_OFS_CTRL3     4'h2
`define ADSQ_OFS_BUFLEN    4'h3
`define ADSQ_OFS_CH123     4'h4
`define ADSQ_OFS_CH0       4'h5
`define ADSQ_OFS_SCAN_LO   4'h6
`define ADSQ_OFS_SCAN_HI   4'h7

// Control one fields
`define ADSQ_B_RES         10
`define ADSQ_B_TRIG_LO     5
`define ADSQ_B_SIM         3
`define ADSQ_B_AUTO_SAMPLE_START        2
`define ADSQ_B_SAMPLING_FLAG        1
`define ADSQ_B_DONE        0
`define ADSQ_CTRL1_MASK    16'h04EC

// Control two fields
`define ADSQ_B_REF_LO      13
`define ADSQ_B_SCAN        10
`define ADSQ_B_CNT_LO      8
`define ADSQ_B_BUFFER_HALF_STATUS        7
`define ADSQ_B_RATE_LO     2
`define ADSQ_B_SPLIT       1
`define ADSQ_B_ALT         0
`define ADSQ_CTRL2_MASK    16'hE73F

// Control three fields
`define ADSQ_B_RC          15
`define ADSQ_B_SMPT_LO     8
`define ADSQ_CTRL3_MASK    16'h9F3F

// Other register write masks
`define ADSQ_BUFLEN_MASK   16'h0007
`define ADSQ_CH123_MASK    16'h0707
`define ADSQ_CH0_MASK      16'h9F9F

// Reset value shared by all registers
`define ADSQ_RST_VAL       16'h0000

// Trigger source codes
`define ADSQ_TRIG_SW       3'h0
`define ADSQ_TRIG_PIN      3'h1
`define ADSQ_TRIG_TMR      3'h2
`define ADSQ_TRIG_AUTO     3'h7

// Reference codes
`define ADSQ_REF_EXT_P     3'h1
`define ADSQ_REF_EXT_N     3'h2
`define ADSQ_REF_EXT_PN    3'h3

// Analog input numbers for the channel zero and channel 1-3 muxes
`define ADSQ_AN_REF        5'h1F
`define ADSQ_AN_LO_P       5'h00
`define ADSQ_AN_HI_P       5'h03
`define ADSQ_AN_LO_N       5'h06
`define ADSQ_AN_HI_N       5'h09
`define ADSQ_AN_ONE        5'h01

// Default conversion time in conversion-clock periods
`define ADSQ_CONV_TADS     5'h0C

`endif

// ===== logic/adsq_pkg.sv
// Types of the converter sequencer.
// Assumes the cfg header is visible from the logic folder.
`include "adsq_cfg.svh"
package adsq_pkg;
   typedef enum logic [3:0] {
      ADSQ_IDLE   = 4'b0001,
      ADSQ_SAMPLE = 4'b0010,
      ADSQ_CONV   = 4'b0100,
      ADSQ_NEXT   = 4'b1000
   } adsq_state_type;
   typedef logic [15:0] adsq_word_type;
   typedef logic [4:0]  adsq_input_type;
endpackage

// ===== logic/adsq_sequencer.sv
// Sample and conversion sequencer with control registers for a SAR converter.
// Assumes a synchronous register port, a 100 MHz clock and a front end that reports the end of
// each conversion by conv_end and takes the converter clock as a one-cycle tick.
//
// How it works
// - Converted channels always sample together, whatever the simultaneous bit
// - Twelve-bit mode hides multi-channel fields as zero
// - Auto start restarts sampling and sets flag
// - Software or chosen trigger ends sampling
// - Done set at end, cleared at start
// - Reference field picks supply or external references
// - Scan enable steps channel zero input
// - Channel count picks converted channels
// - Buffer status shows which half fills
// - Increment rate counts operations per event
// - Split mode alternates buffer halves per event
// - Alternate mode swaps groups A and B
// - RC select switches conversion clock source
// - Auto sample time in conversion clock periods
// - Conversion period is divider plus one cycles
// - Buffer length is two to the field
// - Channel 1-3 negative input selection
// - Channel 1-3 positive input selection
// - Channel zero negative input selection
// - Channel zero positive input selection
// - Resolution bit picks twelve or ten bits
// - Trigger codes pick counter, timer, pin, software
`include "adsq_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module adsq_sequencer #(
   parameter logic [4:0] CONV_TADS = `ADSQ_CONV_TADS
) (
   input  wire logic                    clock,
   input  wire logic                    rst_b,
   input  wire logic [3:0]              reg_addr,
   input  wire adsq_pkg::adsq_word_type reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  adsq_pkg::adsq_word_type reg_rdata_q,
   input  wire logic                    rc_tick,
   input  wire logic                    pin_trig,
   input  wire logic                    timer_trig,
   input  wire logic                    conv_end,
   output var  logic                    tad_tick_q,
   output var  logic [3:0]              hold_sample_q,
   output var  logic                    conv_start_q,
   output var  logic [1:0]              conv_chan_q,
   output var  adsq_pkg::adsq_input_type ch0_pos_q,
   output var  adsq_pkg::adsq_input_type ch0_neg_q,
   output var  adsq_pkg::adsq_input_type ch1_pos_q,
   output var  adsq_pkg::adsq_input_type ch1_neg_q,
   output var  logic [1:0]              ref_sel_q,
   output var  logic                    twelve_bit_q,
   output var  logic                    dma_event_q,
   output var  logic                    buffer_half_status_q,
   output var  logic [7:0]              dma_words_q
);
   import adsq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   adsq_word_type  ctrl1_q, ctrl2_q, ctrl3_q, buflen_q, ch123_q, ch0_q, scan_lo_q, scan_hi_q;
   adsq_state_type state_q;
   logic           sampling_flag_q, done_q, group_b_q, half_q;
   logic [5:0]     div_q;
   logic           tad_q;
   logic [4:0]     tcnt_q;
   logic [1:0]     chan_q;
   logic [3:0]     ops_q;
   logic [4:0]     scan_q;

   // Field views
   logic       twelve;
   logic [2:0] trig;
   logic [1:0] cnt;
   logic       sim;
   logic [1:0] last_chan;
   logic       sw_sampling_flag_wr, sw_sampling_flag_set, sw_sampling_flag_clr, sw_done_clr;
   logic       end_sample, start_conv_go;
   logic [31:0] scan_sel;
   assign twelve      = ctrl1_q[`ADSQ_B_RES];
   assign trig        = ctrl1_q[`ADSQ_B_TRIG_LO +: 3];
   assign cnt         = twelve ? 2'b00 : ctrl2_q[`ADSQ_B_CNT_LO +: 2];
   assign sim         = ~twelve & ctrl1_q[`ADSQ_B_SIM];
   assign last_chan   = cnt[1] ? 2'd3 : (cnt[0] ? 2'd1 : 2'd0);
   assign scan_sel    = {scan_hi_q, scan_lo_q};
   assign sw_sampling_flag_wr  = reg_wr & (reg_addr == `ADSQ_OFS_CTRL1);
   assign sw_sampling_flag_set = sw_sampling_flag_wr & reg_wdata[`ADSQ_B_SAMPLING_FLAG] & ~ctrl1_q[`ADSQ_B_AUTO_SAMPLE_START];
   assign sw_sampling_flag_clr = sw_sampling_flag_wr & ~reg_wdata[`ADSQ_B_SAMPLING_FLAG] & (trig == `ADSQ_TRIG_SW);
   assign sw_done_clr = sw_sampling_flag_wr & ~reg_wdata[`ADSQ_B_DONE];

   // Next selected scan input above the current one, wrapping to the lowest
   function automatic logic [4:0] next_scan(input logic [31:0] sel, input logic [4:0] cur);
      logic [4:0] r;
      logic       hit;
      r   = cur;
      hit = 1'b0;
      for (int i = 1; i <= 32; i++) begin
         if (!hit && sel[5'(cur + 5'(i))]) begin
            r   = 5'(cur + 5'(i));
            hit = 1'b1;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Configuration registers written by software
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl1_q   <= `ADSQ_RST_VAL;
         ctrl2_q   <= `ADSQ_RST_VAL;
         ctrl3_q   <= `ADSQ_RST_VAL;
         buflen_q  <= `ADSQ_RST_VAL;
         ch123_q   <= `ADSQ_RST_VAL;
         ch0_q     <= `ADSQ_RST_VAL;
         scan_lo_q <= `ADSQ_RST_VAL;
         scan_hi_q <= `ADSQ_RST_VAL;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `ADSQ_OFS_CTRL1:   ctrl1_q   <= reg_wdata & `ADSQ_CTRL1_MASK;
            `ADSQ_OFS_CTRL2:   ctrl2_q   <= reg_wdata & `ADSQ_CTRL2_MASK;
            `ADSQ_OFS_CTRL3:   ctrl3_q   <= reg_wdata & `ADSQ_CTRL3_MASK;
            `ADSQ_OFS_BUFLEN:  buflen_q  <= reg_wdata & `ADSQ_BUFLEN_MASK;
            `ADSQ_OFS_CH123:   ch123_q   <= reg_wdata & `ADSQ_CH123_MASK;
            `ADSQ_OFS_CH0:     ch0_q     <= reg_wdata & `ADSQ_CH0_MASK;
            `ADSQ_OFS_SCAN_LO: scan_lo_q <= reg_wdata;
            `ADSQ_OFS_SCAN_HI: scan_hi_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read port, data one cycle after the strobe, unmapped reads as zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= `ADSQ_RST_VAL;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `ADSQ_OFS_CTRL1: begin
               reg_rdata_q <= ctrl1_q;
               reg_rdata_q[`ADSQ_B_SIM]  <= sim;
               reg_rdata_q[`ADSQ_B_SAMPLING_FLAG] <= sampling_flag_q;
               reg_rdata_q[`ADSQ_B_DONE] <= done_q;
            end
            `ADSQ_OFS_CTRL2: begin
               reg_rdata_q <= ctrl2_q;
               reg_rdata_q[`ADSQ_B_CNT_LO +: 2] <= cnt;
               reg_rdata_q[`ADSQ_B_BUFFER_HALF_STATUS]        <= half_q;
            end
            `ADSQ_OFS_CTRL3:   reg_rdata_q <= ctrl3_q;
            `ADSQ_OFS_BUFLEN:  reg_rdata_q <= buflen_q;
            `ADSQ_OFS_CH123:   reg_rdata_q <= twelve ? `ADSQ_RST_VAL : ch123_q;
            `ADSQ_OFS_CH0:     reg_rdata_q <= ch0_q;
            `ADSQ_OFS_SCAN_LO: reg_rdata_q <= scan_lo_q;
            `ADSQ_OFS_SCAN_HI: reg_rdata_q <= scan_hi_q;
            default:           reg_rdata_q <= `ADSQ_RST_VAL;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Conversion clock: divider of the system clock or the RC tick
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 6'h00;
         tad_q <= 1'b0;
      end else if (ctrl3_q[`ADSQ_B_RC]) begin
         div_q <= 6'h00;
         tad_q <= rc_tick;
      end else if (div_q >= ctrl3_q[5:0]) begin
         div_q <= 6'h00;
         tad_q <= 1'b1;
      end else begin
         div_q <= div_q + 6'h01;
         tad_q <= 1'b0;
      end
   end
   assign tad_tick_q = tad_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // End of sampling by the chosen trigger
   always_comb begin
      unique case (trig)
         `ADSQ_TRIG_SW:   end_sample = sw_sampling_flag_clr;
         `ADSQ_TRIG_PIN:  end_sample = pin_trig;
         `ADSQ_TRIG_TMR:  end_sample = timer_trig;
         `ADSQ_TRIG_AUTO: end_sample = tad_q && tcnt_q >= ctrl3_q[`ADSQ_B_SMPT_LO +: 5];
         default:         end_sample = 1'b0;
      endcase
   end
   assign start_conv_go = (state_q == ADSQ_SAMPLE) && end_sample;

   // Sequencer state, sample timer and channel walk
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ADSQ_IDLE;
         tcnt_q  <= 5'h00;
         chan_q  <= 2'd0;
         sampling_flag_q  <= 1'b0;
      end else begin
         unique case (state_q)
            ADSQ_IDLE: begin
               tcnt_q <= 5'h00;
               if (ctrl1_q[`ADSQ_B_AUTO_SAMPLE_START] || sw_sampling_flag_set) begin
                  state_q <= ADSQ_SAMPLE;
                  sampling_flag_q  <= 1'b1;
               end
            end
            ADSQ_SAMPLE: begin
               if (tad_q && tcnt_q != 5'h1F) begin
                  tcnt_q <= tcnt_q + 5'h01;
               end
               if (end_sample) begin
                  state_q <= ADSQ_CONV;
                  sampling_flag_q  <= 1'b0;
                  chan_q  <= 2'd0;
               end
            end
            ADSQ_CONV: begin
               if (conv_end) begin
                  state_q <= ADSQ_NEXT;
               end
            end
            ADSQ_NEXT: begin
               tcnt_q <= 5'h00;
               if (chan_q != last_chan) begin
                  chan_q  <= chan_q + 2'd1;
                  state_q <= ADSQ_CONV;
               end else if (ctrl1_q[`ADSQ_B_AUTO_SAMPLE_START]) begin
                  state_q <= ADSQ_SAMPLE;
                  sampling_flag_q  <= 1'b1;
               end else begin
                  state_q <= ADSQ_IDLE;
               end
            end
            default: state_q <= ADSQ_IDLE;
         endcase
      end
   end

   // Conversion start pulse for every channel converted
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         conv_start_q <= 1'b0;
      end else begin
         conv_start_q <= start_conv_go || (state_q == ADSQ_NEXT && chan_q != last_chan);
      end
   end
   assign conv_chan_q = chan_q;

   // Hold amplifiers of all converted channels sample together, whatever the simultaneous bit
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hold_sample_q <= 4'h0;
      end else if (state_q == ADSQ_SAMPLE) begin
         hold_sample_q <= cnt[1] ? 4'hF : (cnt[0] ? 4'h3 : 4'h1);
      end else if (state_q == ADSQ_CONV && !sim) begin
         hold_sample_q <= 4'h0;
      end else begin
         hold_sample_q <= 4'h0;
      end
   end

   // Done flag, hardware set wins over a software clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= 1'b0;
      end else if (state_q == ADSQ_NEXT && chan_q == last_chan) begin
         done_q <= 1'b1;
      end else if (start_conv_go || sw_done_clr) begin
         done_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Group alternation stepped once per sequence, scan pointer after each group A sequence
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         group_b_q <= 1'b0;
         scan_q    <= 5'h00;
      end else if (state_q == ADSQ_NEXT && chan_q == last_chan) begin
         group_b_q <= ctrl2_q[`ADSQ_B_ALT] & ~group_b_q;
         if (ctrl2_q[`ADSQ_B_SCAN] && !group_b_q) begin
            scan_q <= next_scan(scan_sel, ch0_pos_q);
         end
      end
   end

   // Input multiplexer selections for the active group
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ch0_pos_q <= 5'h00;
         ch0_neg_q <= `ADSQ_AN_REF;
         ch1_pos_q <= `ADSQ_AN_LO_P;
         ch1_neg_q <= `ADSQ_AN_REF;
      end else begin
         if (!group_b_q && ctrl2_q[`ADSQ_B_SCAN]) begin
            ch0_pos_q <= scan_sel[scan_q] ? scan_q : next_scan(scan_sel, scan_q);
         end else begin
            ch0_pos_q <= group_b_q ? ch0_q[12:8] : ch0_q[4:0];
         end
         ch0_neg_q <= (group_b_q ? ch0_q[15] : ch0_q[7]) ? `ADSQ_AN_ONE : `ADSQ_AN_REF;
         ch1_pos_q <= (group_b_q ? ch123_q[8] : ch123_q[0]) ? `ADSQ_AN_HI_P : `ADSQ_AN_LO_P;
         unique case (group_b_q ? ch123_q[10:9] : ch123_q[2:1])
            2'b11:   ch1_neg_q <= `ADSQ_AN_HI_N;
            2'b10:   ch1_neg_q <= `ADSQ_AN_LO_N;
            default: ch1_neg_q <= `ADSQ_AN_REF;
         endcase
      end
   end

   // Reference pair: bit 1 external positive, bit 0 external negative
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ref_sel_q    <= 2'b00;
         twelve_bit_q <= 1'b0;
         dma_words_q  <= 8'h01;
      end else begin
         unique case (ctrl2_q[`ADSQ_B_REF_LO +: 3])
            `ADSQ_REF_EXT_P:  ref_sel_q <= 2'b10;
            `ADSQ_REF_EXT_N:  ref_sel_q <= 2'b01;
            `ADSQ_REF_EXT_PN: ref_sel_q <= 2'b11;
            default:          ref_sel_q <= 2'b00;
         endcase
         twelve_bit_q <= twelve;
         dma_words_q  <= 8'h01 << buflen_q[2:0];
      end
   end

   // Operation counter, DMA event and buffer half
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ops_q       <= 4'h0;
         dma_event_q <= 1'b0;
         half_q      <= 1'b0;
      end else begin
         dma_event_q <= 1'b0;
         if (state_q == ADSQ_NEXT && chan_q == last_chan) begin
            if (ops_q >= ctrl2_q[`ADSQ_B_RATE_LO +: 4]) begin
               ops_q       <= 4'h0;
               dma_event_q <= 1'b1;
               half_q      <= ctrl2_q[`ADSQ_B_SPLIT] & ~half_q;
            end else begin
               ops_q <= ops_q + 4'h1;
            end
         end
      end
   end
   assign buffer_half_status_q = half_q;

endmodule
`default_nettype wire

// ===== testbench/adsq_front_model.sv
// Behavioural analog front end: times each conversion and makes the RC ticks.
// Assumes conv_start is a one-cycle pulse; slow picks the long conversion time.
`timescale 1ns/10ps
`default_nettype none
module adsq_front_model (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic conv_start,
   input  wire logic slow,
   output var  logic conv_end_q,
   output var  logic rc_tick_q
);
   logic [4:0] busy_q;
   logic [2:0] rc_q;
   ////////////////////////////////////////
   // Conversion timer, one end pulse when it runs out
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy_q     <= 5'h00;
         conv_end_q <= 1'b0;
      end else begin
         conv_end_q <= busy_q == 5'h01;
         if (conv_start) busy_q <= slow ? 5'h14 : 5'h03;
         else if (busy_q != 5'h00) busy_q <= busy_q - 5'h01;
      end
   end
   // Free RC oscillator, one tick in seven cycles
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rc_q      <= 3'h0;
         rc_tick_q <= 1'b0;
      end else begin
         rc_q      <= rc_q == 3'h6 ? 3'h0 : rc_q + 3'h1;
         rc_tick_q <= rc_q == 3'h0;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/adsq_sequencer_monitor.sv
// Port assertions for the sequencer, bound into each instance.
// Assumes shadow copies of written registers predict the static outputs.
`timescale 1ns/10ps
`default_nettype none
module adsq_sequencer_monitor (
   input wire logic                     clock,
   input wire logic                     rst_b,
   input wire logic [3:0]               reg_addr,
   input wire adsq_pkg::adsq_word_type  reg_wdata,
   input wire logic                     reg_wr,
   input wire logic                     rc_tick,
   input wire logic                     tad_tick_q,
   input wire logic [3:0]               hold_sample_q,
   input wire adsq_pkg::adsq_input_type ch0_pos_q,
   input wire adsq_pkg::adsq_input_type ch0_neg_q,
   input wire adsq_pkg::adsq_input_type ch1_pos_q,
   input wire adsq_pkg::adsq_input_type ch1_neg_q,
   input wire logic [1:0]               ref_sel_q,
   input wire logic                     twelve_bit_q,
   input wire logic                     dma_event_q,
   input wire logic                     buffer_half_status_q,
   input wire logic [7:0]               dma_words_q
);
   import adsq_pkg::*;
   adsq_word_type sh_q [6];
   logic [6:0]    age_q;
   logic [6:0]    gap_q;
   wire  logic    ok = age_q > 7'h01;
   ////////////////////////////////////////
   // Shadow of each written register at offsets 0 to 5
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 6; i++) sh_q[i] <= 16'h0000;
      end else if (reg_wr && reg_addr < 4'h6) begin
         sh_q[reg_addr[2:0]] <= reg_wdata;
      end
   end
   // Cycles since the last write and since the last tick
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) age_q <= 7'h00;
      else if (reg_wr) age_q <= 7'h00;
      else if (age_q != 7'h7F) age_q <= age_q + 7'h01;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) gap_q <= 7'h00;
      else if (tad_tick_q) gap_q <= 7'h00;
      else if (gap_q != 7'h7F) gap_q <= gap_q + 7'h01;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   chk_ref_map: assert property (ok |-> ref_sel_q ==
      (sh_q[1][15] ? 2'b00 : {sh_q[1][13], sh_q[1][14]})) else $error("reference select wrong");
   chk_words_pow: assert property (ok |-> dma_words_q == 8'h01 << sh_q[3][2:0])
      else $error("buffer words wrong");
   chk_width_mode: assert property (ok |-> twelve_bit_q == sh_q[0][10])
      else $error("resolution wrong");
   chk_ch0_mux: assert property (ok && !sh_q[1][0] && !sh_q[1][10] |->
      ch0_pos_q == sh_q[5][4:0] && ch0_neg_q == (sh_q[5][7] ? 5'h01 : 5'h1F))
      else $error("channel zero mux wrong");
   chk_ch1_mux: assert property (ok && !sh_q[1][0] && !sh_q[0][10] |->
      ch1_pos_q == (sh_q[4][0] ? 5'h03 : 5'h00) &&
      ch1_neg_q == (sh_q[4][2] ? (sh_q[4][1] ? 5'h09 : 5'h06) : 5'h1F))
      else $error("channel one mux wrong");
   chk_hold_count: assert property (ok && hold_sample_q != 4'h0 |-> hold_sample_q ==
      (sh_q[0][10] ? 4'h1 : sh_q[1][9] ? 4'hF : sh_q[1][8] ? 4'h3 : 4'h1))
      else $error("hold channels wrong");
   chk_tad_period: assert property (age_q == 7'h7F && !sh_q[2][15] && tad_tick_q
      |-> gap_q == {1'b0, sh_q[2][5:0]}) else $error("conversion clock period wrong");
   chk_rc_source: assert property (ok && sh_q[2][15] && tad_tick_q
      |-> $past(rc_tick) || $past(rc_tick, 2)) else $error("tick without rc tick");
   chk_half_cause: assert property (ok && $changed(buffer_half_status_q)
      |-> dma_event_q || $past(dma_event_q)) else $error("half status moved alone");
   cov_event: cover property (dma_event_q);
   cov_half: cover property ($rose(buffer_half_status_q));
   cov_hold: cover property (hold_sample_q == 4'hF);
endmodule
bind adsq_sequencer adsq_sequencer_monitor mon (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .rc_tick, .tad_tick_q, .hold_sample_q, .ch0_pos_q, .ch0_neg_q, .ch1_pos_q, .ch1_neg_q,
   .ref_sel_q, .twelve_bit_q, .dma_event_q, .buffer_half_status_q, .dma_words_q);
`default_nettype wire

// ===== testbench/adsq_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the front-end model and the monitor are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module adsq_sequencer_tb;
   import adsq_pkg::*;
   logic           clock, rst_b, reg_wr, reg_rd, pin_trig, timer_trig, slow;
   logic           conv_end, rc_tick, tad_tick_q, conv_start_q, dma_event_q;
   logic           buffer_half_status_q, twelve_bit_q;
   logic [3:0]     reg_addr, hold_sample_q, h, a;
   logic [1:0]     conv_chan_q, ref_sel_q;
   logic [7:0]     dma_words_q;
   adsq_word_type  reg_wdata, reg_rdata_q, v, d;
   adsq_input_type ch0_pos_q, ch0_neg_q, ch1_pos_q, ch1_neg_q, p;
   int             n_mismatch, comparisons, starts, events, seed, s0, e0;
   adsq_sequencer dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .rc_tick, .pin_trig, .timer_trig, .conv_end, .tad_tick_q, .hold_sample_q, .conv_start_q,
      .conv_chan_q, .ch0_pos_q, .ch0_neg_q, .ch1_pos_q, .ch1_neg_q, .ref_sel_q, .twelve_bit_q,
      .dma_event_q, .buffer_half_status_q, .dma_words_q);
   adsq_front_model fe (.clock(clock), .rst_b(rst_b), .conv_start(conv_start_q),
      .slow(slow), .conv_end_q(conv_end), .rc_tick_q(rc_tick));
   ////////////////////////////////////////
   // Clock and port event counters
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (conv_start_q === 1'b1) starts <= starts + 1;
      if (dma_event_q === 1'b1) events <= events + 1;
   end
   ////////////////////////////////////////
   // Expected values
   function automatic logic [3:0] hold_exp(input logic [1:0] c);
      return c[1] ? 4'hF : c[0] ? 4'h3 : 4'h1;
   endfunction
   function automatic logic [1:0] ref_exp(input logic [2:0] r);
      return r[2] ? 2'b00 : {r[0], r[1]};
   endfunction
   // Port helpers
   task automatic cyc(input logic w, input logic r, input logic [3:0] ad, input adsq_word_type dt);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= ad;
      reg_wdata <= dt;
      @(posedge clock);
   endtask
   task automatic wr(input logic [3:0] ad, input adsq_word_type dt);
      cyc(1'b1, 1'b0, ad, dt);
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   task automatic rd(input logic [3:0] ad, output adsq_word_type dt);
      cyc(1'b0, 1'b1, ad, 16'h0000);
      idle(1);
      dt = reg_rdata_q;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_done;
      v = 16'h0000;
      for (int i = 0; i < 100 && v[0] !== 1'b1; i++) rd(4'h0, v);
      chk("done", 16'h0001, {15'h0000, v[0]});
   endtask
   task automatic op(input adsq_word_type b, output logic [3:0] hs, output adsq_input_type s);
      slow <= 1'($random(seed));
      wr(4'h0, b | 16'h0002);
      idle(3);
      hs = hold_sample_q;
      s = ch0_pos_q;
      wr(4'h0, b);
      wait_done();
      idle(2);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      finish_test();
   end
   // Main sequence
   initial begin
      seed = 32;
      n_mismatch = 0;
      comparisons = 0;
      starts = 0;
      events = 0;
      {reg_wr, reg_rd, pin_trig, timer_trig, slow, rst_b} = 6'h00;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (int k = 0; k < 9; k++) begin
         rd(4'(k), v);
         chk("reset", 16'h0000, v);
      end
      wr(4'h1, 16'hFFFF);
      rd(4'h1, v);
      chk("ctrl2", 16'hE73F, v);
      wr(4'h0, 16'h0408);
      wr(4'h1, 16'h0300);
      wr(4'h4, 16'h0707);
      rd(4'h0, v);
      chk("ctrl1_12", 16'h0400, v);
      rd(4'h1, v);
      chk("ctrl2_12", 16'h0000, v);
      rd(4'h4, v);
      chk("ch123_12", 16'h0000, v);
      s0 = starts;
      op(16'h0400, h, p);
      chk("hold_12", 16'h0001, {12'h000, h});
      chk("starts_12", 16'h0001, 16'(starts - s0));
      wr(4'h4, 16'h0000);
      wr(4'h1, 16'h0000);
      wr(4'h0, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         wr(4'h1, {6'h00, 2'(c), 8'h00});
         s0 = starts;
         e0 = events;
         op(c[0] ? 16'h0008 : 16'h0000, h, p);
         chk("hold", {12'h000, hold_exp(2'(c))}, {12'h000, h});
         chk("starts", 16'($countones(hold_exp(2'(c)))), 16'(starts - s0));
         chk("event", 16'h0001, 16'(events - e0));
      end
      wr(4'h1, 16'h003C);
      e0 = events;
      repeat (15) op(16'h0000, h, p);
      chk("rate15", 16'h0000, 16'(events - e0));
      op(16'h0000, h, p);
      chk("rate16", 16'h0001, 16'(events - e0));
      wr(4'h1, 16'h0002);
      for (int i = 0; i < 2; i++) begin
         op(16'h0000, h, p);
         rd(4'h1, v);
         chk("half", i != 0 ? 16'h0002 : 16'h0082, v);
      end
      wr(4'h0, 16'h0001);
      rd(4'h0, v);
      chk("done_w1", 16'h0001, v);
      wr(4'h0, 16'h0000);
      rd(4'h0, v);
      chk("done_w0", 16'h0000, v);
      wr(4'h5, 16'h0905);
      wr(4'h1, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         op(16'h0000, h, p);
         chk("alt", i[0] ? 16'h0009 : 16'h0005, {11'h000, p});
      end
      wr(4'h5, 16'h0000);
      wr(4'h6, 16'h0014);
      wr(4'h1, 16'h0400);
      for (int i = 0; i < 3; i++) begin
         op(16'h0000, h, p);
         chk("scan", i == 1 ? 16'h0004 : 16'h0002, {11'h000, p});
      end
      wr(4'h6, 16'h0000);
      wr(4'h1, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         s0 = starts;
         wr(4'h0, k != 0 ? 16'h0042 : 16'h0022);
         idle(6);
         chk("no_trig", 16'h0000, 16'(starts - s0));
         pin_trig <= k == 0;
         timer_trig <= k == 1;
         idle(1);
         pin_trig <= 1'b0;
         timer_trig <= 1'b0;
         wait_done();
         chk("trig", 16'h0001, 16'(starts - s0));
      end
      wr(4'h2, 16'h0301);
      wr(4'h0, 16'h00E4);
      s0 = starts;
      idle(300);
      chk("auto", 16'h0001, 16'(starts - s0 > 5));
      wr(4'h0, 16'h0000);
      idle(100);
      s0 = starts;
      idle(100);
      chk("manual", 16'h0000, 16'(starts - s0));
      wr(4'h2, 16'h8000);
      idle(40);
      for (int k = 0; k < 8; k++) begin
         wr(4'h1, {3'(k), 13'h0000});
         wr(4'h3, 16'(k));
         idle(3);
         chk("ref", {14'h0000, ref_exp(3'(k))}, {14'h0000, ref_sel_q});
         chk("words", 16'h0001 << k, {8'h00, dma_words_q});
      end
      for (int n = 0; n < 40; n++) begin
         a = 4'h2 + 4'($random(seed) & 3);
         d = 16'($random(seed));
         wr(a, d);
         rd(a, v);
         chk("rw", d & (a == 4'h2 ? 16'h9F3F : a == 4'h3 ? 16'h0007 :
            a == 4'h4 ? 16'h0707 : 16'h9F9F), v);
         idle(2);
      end
      finish_test();
   end
endmodule
`default_nettype wire
